// File: core/dgus_map.svh
// How it works
// RULE1: control bit 0 starts first converter update
// RULE2: software checks busy clear before requesting
// RULE3: control bit 1 updates second converter
// RULE4: request bits write-one-set, reset to zero
// RULE5: settle flag bit 8, cleared after 10us
// RULE6: status bit 9 is second settle flag
// RULE7: busy set by configuration write and transfer
// RULE8: busy set by data write and transfer
// RULE9: busy set by status read request
// RULE10: busy clears only when control logic idle
// RULE11: status bit 1 is second busy flag
// RULE12: status read-only, reserved bits read zero
// RULE13: configuration write queues transfer, busy until done
// RULE14: settle timer counts clocks, restarts each update
`ifndef DGUS_MAP_SVH
`define DGUS_MAP_SVH

`define DGUS_ADDR_W        12
`define DGUS_CTRL_OFF      12'h158
`define DGUS_STAT_OFF      12'h15c
`define DGUS_REQ_RST       2'h0
`define DGUS_BUSY_LSB      0
`define DGUS_SETTLE_LSB    8
`define DGUS_CLK_PERIOD_NS 25
`define DGUS_SETTLE_NS     10000
`define DGUS_SETTLE_CYC    ((`DGUS_SETTLE_NS + `DGUS_CLK_PERIOD_NS - 1) / `DGUS_CLK_PERIOD_NS)
`define DGUS_SETTLE_W      9

`endif

// File: core/dgus_pkg.sv
package dgus_pkg;

  typedef enum logic [2:0] {
    DGUS_IDLE = 3'h1,
    DGUS_XFER = 3'h2,
    DGUS_LOAD = 3'h4
  } dgus_state_e;

  typedef enum logic [1:0] {
    DGUS_KIND_CFG  = 2'h0,
    DGUS_KIND_DATA = 2'h1,
    DGUS_KIND_STAT = 2'h2
  } dgus_kind_e;

  typedef struct packed {
    logic [8:0] cnt;
    logic       settling;
  } dgus_timer_s;

  typedef struct packed {
    dgus_state_e [1:0] st;
    dgus_kind_e  [1:0] kind;
    logic [1:0]        req;
    logic [1:0]        pend_cfg;
    logic [1:0]        pend_data;
    logic [1:0]        pend_stat;
    logic [1:0]        busy;
    logic [1:0]        upd;
    logic [1:0]        xstart;
    logic [31:0]       rdata;
    logic              rvalid;
  } dgus_top_s;

endpackage

// File: core/dgus_settle_timer.sv
`timescale 1ns/10ps
`include "dgus_map.svh"

module dgus_settle_timer (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // update event
  input  wire logic i_start,
  // settle flag
  output logic      o_settling
);

  dgus_pkg::dgus_timer_s r_reg;
  dgus_pkg::dgus_timer_s r_next;

  always_comb begin
    r_next = r_reg;
    if (i_start) begin
      r_next.cnt = `DGUS_SETTLE_W'(`DGUS_SETTLE_CYC); // RULE14
    end else if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - `DGUS_SETTLE_W'(1); // RULE5
    end
    r_next.settling = (r_next.cnt != '0);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_settling = r_reg.settling;

  chk_settle_reload: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE14
    i_start |=> (r_reg.cnt == `DGUS_SETTLE_W'(`DGUS_SETTLE_CYC)) && o_settling)
    else $error("settle timer not reloaded on update");

  chk_settle_expiry: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE5
    (r_reg.cnt == `DGUS_SETTLE_W'(1)) && !i_start |=> !o_settling ##1 !o_settling || $past(i_start))
    else $error("settle flag outlived its timer");

endmodule

// File: core/dgus_top.sv
`timescale 1ns/10ps
`include "dgus_map.svh"

module dgus_top #(
  parameter bit P_DUAL = 1'b1
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // register port
  input  wire logic [11:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  output logic             o_reg_rvalid,
  // per-converter register events
  input  wire logic [1:0]  i_cfg_wr,
  input  wire logic [1:0]  i_data_wr,
  input  wire logic [1:0]  i_stat_req,
  // converter link
  input  wire logic [1:0]  i_xfer_done,
  output logic      [1:0]  o_xfer_start,
  output logic      [3:0]  o_xfer_kind,
  output logic      [1:0]  o_update
);

  dgus_pkg::dgus_top_s r_reg;
  dgus_pkg::dgus_top_s r_next;

  logic [1:0] conv_en;
  logic [1:0] settle;
  logic [1:0] ctl_set;
  logic [31:0] status_word;

  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    addr_hit = (addr[11:2] == off[11:2]);
  endfunction

  // second converter present only on the dual variant
  assign conv_en = {P_DUAL, 1'b1}; // RULE3

  // write-one-set of the update request bits
  assign ctl_set = (i_reg_wr && addr_hit(i_reg_addr, `DGUS_CTRL_OFF)) ? (i_reg_wdata[1:0] & conv_en) : 2'h0; // RULE4

  // status word with reserved bits at zero
  always_comb begin
    status_word = 32'h0; // RULE12
    status_word[`DGUS_BUSY_LSB +: 2] = r_reg.busy; // RULE11
    status_word[`DGUS_SETTLE_LSB +: 2] = settle & conv_en; // RULE6
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_timer
      dgus_settle_timer u_settle (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_start    (r_reg.upd[g]),
        .o_settling (settle[g])
      );
    end
  endgenerate

  always_comb begin
    r_next = r_reg;
    r_next.upd = 2'h0;
    r_next.xstart = 2'h0;
    for (int c = 0; c < 2; c++) begin
      case (r_reg.st[c])
        dgus_pkg::DGUS_IDLE: begin
          if (r_reg.pend_cfg[c]) begin
            r_next.st[c] = dgus_pkg::DGUS_XFER; // RULE13
            r_next.kind[c] = dgus_pkg::DGUS_KIND_CFG;
            r_next.xstart[c] = 1'b1;
            r_next.pend_cfg[c] = 1'b0;
          end else if (r_reg.pend_data[c]) begin
            r_next.st[c] = dgus_pkg::DGUS_XFER; // RULE8
            r_next.kind[c] = dgus_pkg::DGUS_KIND_DATA;
            r_next.xstart[c] = 1'b1;
            r_next.pend_data[c] = 1'b0;
          end else if (r_reg.pend_stat[c]) begin
            r_next.st[c] = dgus_pkg::DGUS_XFER; // RULE9
            r_next.kind[c] = dgus_pkg::DGUS_KIND_STAT;
            r_next.xstart[c] = 1'b1;
            r_next.pend_stat[c] = 1'b0;
          end else if (r_reg.req[c]) begin
            r_next.st[c] = dgus_pkg::DGUS_LOAD; // RULE1
            r_next.upd[c] = 1'b1;
          end
        end
        dgus_pkg::DGUS_XFER: begin
          if (i_xfer_done[c]) begin
            r_next.st[c] = dgus_pkg::DGUS_IDLE;
          end
        end
        dgus_pkg::DGUS_LOAD: begin
          r_next.st[c] = dgus_pkg::DGUS_IDLE;
          r_next.req[c] = 1'b0; // RULE4
        end
        default: begin
          r_next.st[c] = dgus_pkg::DGUS_IDLE;
        end
      endcase
      // new events win over the clears above
      r_next.pend_cfg[c] = r_next.pend_cfg[c] | (i_cfg_wr[c] & conv_en[c]); // RULE7
      r_next.pend_data[c] = r_next.pend_data[c] | (i_data_wr[c] & conv_en[c]); // RULE8
      r_next.pend_stat[c] = r_next.pend_stat[c] | (i_stat_req[c] & conv_en[c]); // RULE9
      r_next.req[c] = r_next.req[c] | ctl_set[c]; // RULE1
      r_next.busy[c] = (r_next.st[c] != dgus_pkg::DGUS_IDLE) | r_next.pend_cfg[c] // RULE10
                     | r_next.pend_data[c] | r_next.pend_stat[c];
    end
    // register read, unmapped offsets read zero
    r_next.rvalid = i_reg_rd;
    if (!i_reg_rd) begin
      r_next.rdata = 32'h0;
    end else if (addr_hit(i_reg_addr, `DGUS_CTRL_OFF)) begin
      r_next.rdata = {30'h0, r_reg.req}; // RULE12
    end else if (addr_hit(i_reg_addr, `DGUS_STAT_OFF)) begin
      r_next.rdata = status_word; // RULE12
    end else begin
      r_next.rdata = 32'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r_reg <= '0;
      r_reg.req <= `DGUS_REQ_RST; // RULE4
      r_reg.st[0] <= dgus_pkg::DGUS_IDLE;
      r_reg.st[1] <= dgus_pkg::DGUS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_reg_rdata = r_reg.rdata;
  assign o_reg_rvalid = r_reg.rvalid;
  assign o_xfer_start = r_reg.xstart;
  assign o_xfer_kind = {r_reg.kind[1], r_reg.kind[0]};
  assign o_update = r_reg.upd;

  chk_req_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE4
    ctl_set[0] |=> r_reg.req[0] || o_update[0])
    else $error("request bit 0 not set by write of one");

  chk_req_update: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE1
    (r_reg.st[0] == dgus_pkg::DGUS_IDLE) && r_reg.req[0]
      && !(r_reg.pend_cfg[0] | r_reg.pend_data[0] | r_reg.pend_stat[0])
    |=> o_update[0] ##1 !o_update[0])
    else $error("update not issued for pending request");

  chk_req_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE4
    o_update[0] && !ctl_set[0] |=> !r_reg.req[0])
    else $error("request bit not cleared after update");

  chk_cfg_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE7
    i_cfg_wr[0] |=> r_reg.busy[0] ##1 r_reg.busy[0])
    else $error("busy not raised by configuration write");

  chk_data_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE8
    i_data_wr[0] |=> r_reg.busy[0])
    else $error("busy not raised by data write");

  chk_stat_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE9
    i_stat_req[0] |=> r_reg.busy[0])
    else $error("busy not raised by status read request");

  chk_busy_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE10
    $fell(r_reg.busy[0]) |-> $past(i_xfer_done[0]) || ($past(r_reg.st[0]) == dgus_pkg::DGUS_LOAD))
    else $error("busy cleared without transfer end or update");

  chk_second_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE11
    i_cfg_wr[1] && P_DUAL |=> r_reg.busy[1])
    else $error("second busy not raised by configuration write");

  chk_cfg_queue: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    (r_reg.st[0] == dgus_pkg::DGUS_IDLE) && r_reg.pend_cfg[0]
    |=> o_xfer_start[0] && (o_xfer_kind[1:0] == 2'h0)
        && (r_reg.st[0] == dgus_pkg::DGUS_XFER) && r_reg.busy[0])
    else $error("configuration transfer not started when idle");

  chk_rd_reserved: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE12
    o_reg_rvalid |-> (o_reg_rdata[31:10] == 22'h0) && (o_reg_rdata[7:2] == 6'h0))
    else $error("reserved bits read non-zero");

  chk_settle_rd: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE5
    o_update[0] |=> ##1 settle[0])
    else $error("settle flag not raised after update");

  chk_single_rsvd: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE3
    !P_DUAL |-> !r_reg.req[1] && !r_reg.busy[1])
    else $error("second converter active on single variant");

  // second converter request bits, control read and first update strobe
  chk_req1_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE3
    ctl_set[1] |=> r_reg.req[1] || o_update[1])
    else $error("request bit 1 not set by write of one");

  chk_req1_update: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE3
    (r_reg.st[1] == dgus_pkg::DGUS_IDLE) && r_reg.req[1]
      && !(r_reg.pend_cfg[1] | r_reg.pend_data[1] | r_reg.pend_stat[1])
    |=> o_update[1] ##1 !o_update[1])
    else $error("second update not issued for pending request");

  chk_req1_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE4
    o_update[1] && !ctl_set[1] |=> !r_reg.req[1])
    else $error("request bit 1 not cleared after update");

  chk_ctl_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE4
    i_reg_rd && addr_hit(i_reg_addr, `DGUS_CTRL_OFF)
    |=> o_reg_rvalid && (o_reg_rdata == {30'h0, $past(r_reg.req)}))
    else $error("control read does not show request bits");

  chk_upd_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE1
    o_update[0] |=> !o_update[0])
    else $error("update strobe longer than one cycle");

  // busy flags
  chk_data1_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE11
    i_data_wr[1] && P_DUAL |=> r_reg.busy[1])
    else $error("second busy not raised by data write");

  chk_stat1_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE11
    i_stat_req[1] && P_DUAL |=> r_reg.busy[1])
    else $error("second busy not raised by status read request");

  chk_xfer_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE7
    (r_reg.st[0] == dgus_pkg::DGUS_XFER) && !i_xfer_done[0]
    |=> (r_reg.st[0] == dgus_pkg::DGUS_XFER) && r_reg.busy[0])
    else $error("transfer left or busy dropped before done");

  chk_xfer1_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE11
    (r_reg.st[1] == dgus_pkg::DGUS_XFER) && !i_xfer_done[1]
    |=> (r_reg.st[1] == dgus_pkg::DGUS_XFER) && r_reg.busy[1])
    else $error("second transfer left or busy dropped before done");

  chk_busy1_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE11
    $fell(r_reg.busy[1]) |-> $past(i_xfer_done[1]) || ($past(r_reg.st[1]) == dgus_pkg::DGUS_LOAD))
    else $error("second busy cleared without transfer end or update");

  chk_upd_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE10
    o_update[0] |-> r_reg.busy[0])
    else $error("busy clear during update strobe");

  // transfer start and kind
  chk_data_queue: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE8
    (r_reg.st[0] == dgus_pkg::DGUS_IDLE) && !r_reg.pend_cfg[0] && r_reg.pend_data[0]
    |=> o_xfer_start[0] && (o_xfer_kind[1:0] == 2'h1) && (r_reg.st[0] == dgus_pkg::DGUS_XFER))
    else $error("data transfer not started when idle");

  chk_stat_queue: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE9
    (r_reg.st[0] == dgus_pkg::DGUS_IDLE) && !r_reg.pend_cfg[0] && !r_reg.pend_data[0] && r_reg.pend_stat[0]
    |=> o_xfer_start[0] && (o_xfer_kind[1:0] == 2'h2) && (r_reg.st[0] == dgus_pkg::DGUS_XFER))
    else $error("status transfer not started when idle");

  chk_cfg1_queue: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    (r_reg.st[1] == dgus_pkg::DGUS_IDLE) && r_reg.pend_cfg[1]
    |=> o_xfer_start[1] && (o_xfer_kind[3:2] == 2'h0) && (r_reg.st[1] == dgus_pkg::DGUS_XFER))
    else $error("second configuration transfer not started when idle");

  chk_start_once: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    o_xfer_start[0] |=> !o_xfer_start[0])
    else $error("transfer start longer than one cycle");

  chk_start1_once: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    o_xfer_start[1] |=> !o_xfer_start[1])
    else $error("second transfer start longer than one cycle");

  chk_kind_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    !o_xfer_start[0] |-> $stable(o_xfer_kind[1:0]))
    else $error("transfer kind changed without a start");

  chk_kind1_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
    !o_xfer_start[1] |-> $stable(o_xfer_kind[3:2]))
    else $error("second transfer kind changed without a start");

  // register read port
  chk_rd_valid: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE12
    i_reg_rd |=> o_reg_rvalid)
    else $error("read answer missing");

  chk_rd_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE12
    !i_reg_rd |=> !o_reg_rvalid && (o_reg_rdata == 32'h0))
    else $error("read answer without a read");

  chk_stat_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE12
    i_reg_rd && addr_hit(i_reg_addr, `DGUS_STAT_OFF)
    |=> o_reg_rvalid && (o_reg_rdata[9:8] == $past(settle)) && (o_reg_rdata[1:0] == $past(r_reg.busy)))
    else $error("status read does not show busy and settle flags");

  // settle flags and single variant
  chk_settle1_rd: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE6
    o_update[1] |=> ##1 settle[1])
    else $error("second settle flag not raised after update");

  chk_settle_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE5
    !settle[0] && !o_update[0] |=> !settle[0])
    else $error("settle flag raised without an update");

  chk_single_ctl: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE3
    !P_DUAL |-> !o_update[1] && !o_xfer_start[1] && !settle[1])
    else $error("second converter driven on single variant");

  chk_single_rd: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE12
    !P_DUAL && o_reg_rvalid |-> !o_reg_rdata[9] && !o_reg_rdata[1])
    else $error("reserved second converter bits read non-zero");

endmodule

// File: verif/dgus_conv_model.sv
`timescale 1ns/10ps

module dgus_conv_model #(
  parameter int P_DELAY = 20
) (
  // clock
  input  wire logic       i_clk,
  // transfer handshake
  input  wire logic [1:0] i_start,
  output logic      [1:0] o_done
);
  int cnt [2];

  initial begin
    o_done = 2'h0;
    cnt    = '{0, 0};
  end

  // each transfer finishes after a fixed delay with a one-cycle done pulse
  always @(posedge i_clk) begin
    for (int c = 0; c < 2; c++) begin
      o_done[c] <= (cnt[c] == 1);
      if (i_start[c]) begin
        cnt[c] <= P_DELAY;
      end else if (cnt[c] > 0) begin
        cnt[c] <= cnt[c] - 1;
      end
    end
  end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/10ps

module tb_top;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [11:0] addr = 12'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [5:0]  ev = 6'h0;
  logic [31:0] rdata;
  logic        rvalid;
  logic [1:0]  done;
  logic [1:0]  start;
  logic [3:0]  kind;
  logic [1:0]  upd;
  logic [31:0] rdata_s;
  logic        rvalid_s;
  logic [1:0]  done_s;
  logic [1:0]  start_s;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n_upd [2] = '{0, 0};

  always #12.5 i_clk = ~i_clk;

  dgus_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_cfg_wr(ev[1:0]), .i_data_wr(ev[3:2]),
    .i_stat_req(ev[5:4]), .i_xfer_done(done), .o_xfer_start(start), .o_xfer_kind(kind), .o_update(upd));

  dgus_conv_model conv_u (.i_clk(i_clk), .i_start(start), .o_done(done));

  // single-converter variant fed with the same stimulus
  dgus_top #(.P_DUAL(1'b0)) dut_single_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata_s), .o_reg_rvalid(rvalid_s), .i_cfg_wr(ev[1:0]),
    .i_data_wr(ev[3:2]), .i_stat_req(ev[5:4]), .i_xfer_done(done_s), .o_xfer_start(start_s), .o_xfer_kind(),
    .o_update());

  dgus_conv_model conv_single_u (.i_clk(i_clk), .i_start(start_s), .o_done(done_s));

  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    for (int c = 0; c < 2; c++) begin
      if (upd[c] === 1'b1) begin
        n_upd[c]++;
      end
    end
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
    int i;
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk);
    rd   <= 1'b0;
    for (i = 0; i < 3; i++) begin
      #1;
      if (rvalid === 1'b1) break;
      @(posedge i_clk);
    end
    chk("read valid", 32'h1, {31'h0, rvalid});
    chk("read data", exp, rdata);
    chk("single read valid", 32'h1, {31'h0, rvalid_s});
    chk("single read data", exp & 32'hfffffdfd, rdata_s);
  endtask

  // wait for a strobe on bit c of sig (0 update, 1 start, 2 done) with a bound
  task automatic wait_for(input int s, input int c);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge i_clk);
      #1;
      if ((s == 0 ? upd[c] : s == 1 ? start[c] : done[c]) === 1'b1) break;
    end
    chk("strobe seen", 32'h1, {31'h0, i < 60});
  endtask

  initial begin
    int base;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    reg_rd(12'h158, 32'h0);
    reg_rd(12'h15c, 32'h0);
    for (int c = 0; c < 2; c++) begin
      reg_rd(12'h15c, 32'h0);
      reg_wr(12'h158, 32'h1 << c);
      wait_for(0, c);
      repeat (10) @(posedge i_clk);
      reg_rd(12'h15c, 32'h100 << c);
      reg_rd(12'h158, 32'h0);
      repeat (420) @(posedge i_clk);
      reg_rd(12'h15c, 32'h0);
    end
    reg_wr(12'h158, 32'h1);
    wait_for(0, 0);
    repeat (200) @(posedge i_clk);
    reg_wr(12'h158, 32'hfffffffd);
    wait_for(0, 0);
    repeat (300) @(posedge i_clk);
    reg_rd(12'h15c, 32'h100);
    repeat (120) @(posedge i_clk);
    reg_rd(12'h15c, 32'h0);
    base = n_upd[0] + n_upd[1];
    reg_wr(12'h158, 32'h0);
    reg_wr(12'h15c, 32'hffffffff);
    repeat (10) @(posedge i_clk);
    chk("update count", base, n_upd[0] + n_upd[1]);
    reg_rd(12'h15c, 32'h0);
    reg_rd(12'h100, 32'h0);
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 2; c++) begin
        @(posedge i_clk);
        ev[2 * k + c] <= 1'b1;
        @(posedge i_clk);
        ev <= 6'h0;
        wait_for(1, c);
        chk("kind", k, {30'h0, kind[2 * c +: 2]});
        reg_rd(12'h15c, 32'h1 << c);
        wait_for(2, c);
        repeat (3) @(posedge i_clk);
        reg_rd(12'h15c, 32'h0);
      end
    end
    report_and_stop();
  end
endmodule
